// File: rtl/eebsf_pkg.sv
// Constants and types shared by the EEPROM bus slave front end
package eebsf_pkg;

   // ==========================================================
   // Clock and power-up timing
   // ==========================================================
   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned T_INIT_MS      = 10;
   // Least wait before the first command, in whole clock cycles (integer divide, no rounding up)
   localparam int unsigned INIT_CYCLES    = (T_INIT_MS * (CLK_HZ / 1000));

   // ==========================================================
   // Input synchroniser layout
   // ==========================================================
   localparam int unsigned SYNC_W         = 8;
   localparam int unsigned IX_SCL         = 0;
   localparam int unsigned IX_SDA         = 1;
   localparam int unsigned IX_CS0         = 2;
   localparam int unsigned IX_CS1         = 3;
   localparam int unsigned IX_CS2         = 4;
   localparam int unsigned IX_WP          = 5;
   localparam int unsigned IX_POR         = 6;
   localparam int unsigned IX_BOR         = 7;
   // Idle bus lines high, every other pin low
   localparam logic [7:0]  SYNC_RST       = 8'h03;

   // ==========================================================
   // Byte framing
   // ==========================================================
   localparam logic [3:0]  BIT_CNT_RST    = 4'h0;
   localparam logic [3:0]  BITS_IN_BYTE   = 4'h8;
   localparam logic [3:0]  BITS_WITH_ACK  = 4'h9;
   localparam logic [7:0]  BYTE_RST       = 8'h00;
   localparam logic [15:0] WADDR_RST      = 16'h0000;

   // ==========================================================
   // Device address byte fields
   // ==========================================================
   localparam int unsigned DEV_TYPE_HI    = 7;
   localparam int unsigned DEV_TYPE_LO    = 4;
   localparam int unsigned DEV_CS_HI      = 3;
   localparam int unsigned DEV_CS_LO      = 1;
   localparam int unsigned DEV_RW_BIT     = 0;
   localparam logic [3:0]  TYPE_ARRAY     = 4'ha;
   localparam logic [3:0]  TYPE_ID_SPACE  = 4'hb;

   // ==========================================================
   // Identification space function field in the word address
   // ==========================================================
   localparam int unsigned FN_HI          = 11;
   localparam int unsigned FN_LO          = 9;
   localparam logic [2:0]  FN_ID_PAGE     = 3'h0;
   localparam logic [2:0]  FN_UNIQUE_ID   = 3'h1;
   localparam logic [2:0]  FN_LOCK        = 3'h2;
   localparam logic [2:0]  FN_RST         = 3'h0;

   // ==========================================================
   // Protocol states, Gray coded along the usual path
   // ==========================================================
   typedef enum logic [2:0]
   {
      EEBSF_IDLE     = 3'h0,
      EEBSF_DEV_ADDR = 3'h1,
      EEBSF_ADDR_HI  = 3'h3,
      EEBSF_ADDR_LO  = 3'h2,
      EEBSF_WR_DATA  = 3'h6,
      EEBSF_RD_DATA  = 3'h7,
      EEBSF_WAIT     = 3'h5
   } eebsf_state_t;

endpackage

// File: rtl/eebsf_front_end.sv
// Slave front end of a two-wire serial EEPROM: framing, decode, acknowledge
// Overview of operation
// (RULE1) SDA rising while SCL high is a Stop and ends the transaction.
// (RULE2) Stop after a write starts programming; any other Stop means Standby.
// (RULE3) Device pulls SDA low through the whole ninth clock to acknowledge.
// (RULE4) Standby at power-up, after a read's Stop, and when internal work ends.
// (RULE5) Master recovers the bus: Start, nine clocks, Start, then Stop.
// (RULE6) Bus ignored until power-on release; then logic resets into Standby.
// (RULE7) Master waits at least 10 ms of good supply before any command; INIT_CYCLES is not used by the logic.
// (RULE8) Brown-out resets logic; silent until power-on release comes again.
// (RULE9) Write protect high blocks changes to array and identification page.
// (RULE10) Address byte: type bits 7..4, chip select 3..1, read/write bit 0.
// (RULE11) Type 1010 selects the main memory array.
// (RULE12) Type 1011 selects identification page, lock, and unique identifier.
// (RULE13) Respond only when chip-select bits equal the three strap inputs.
// (RULE14) Address bit 0 high means read, low means write.
// (RULE15) Acknowledge address on match, else no acknowledge and go to Standby.
// (RULE16) Two word address bytes follow, high first, each acknowledged.
// (RULE17) Array accesses use all sixteen word address bits.
// (RULE18) Type 1011: bits 11..9 pick page/status, lock, or unique identifier.
// (RULE19) Lock accepted only with type 1011 and a write.
// (RULE20) Unique identifier accepted only with type 1011 and a read.
// (RULE21) Bits sampled on SCL rising edge; output changes on falling edge.
// (RULE22) SDA falling while SCL high is a Start; bus ignored until one.
// (RULE23) Write protect high: address bytes acknowledged, data bytes not.
// (RULE24) SDA only pulled low for acknowledge or read data, never driven high.
// (RULE25) Start mid-transfer aborts the byte and restarts address reception.
`timescale 1ns/100ps
`default_nettype none

module eebsf_front_end
   import eebsf_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        scl_pin,
   input  wire logic        sda_pin_in,
   output logic             sda_pin_out,
   output logic             sda_pin_oe,
   input  wire logic        chip_select_bit_0,
   input  wire logic        chip_select_bit_1,
   input  wire logic        chip_select_bit_2,
   input  wire logic        write_protect_pin,
   input  wire logic        por_released_pin,
   input  wire logic        brown_out_pin,
   input  wire logic        write_busy,
   input  wire logic        id_page_locked,
   input  wire logic [7:0]  rd_byte,
   output logic             standby,
   output logic             bus_stop,
   output logic             prog_start,
   output logic             addr_valid,
   output logic [15:0]      word_address_bits,
   output logic             sel_id_space,
   output logic [2:0]       id_func,
   output logic             op_read,
   output logic             rd_byte_taken,
   output logic             wr_byte_valid,
   output logic [7:0]       wr_byte
);
   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [SYNC_W-1:0] pins_raw, sync1_q, sync2_q, sync3_q, filt_q;
   // Raw pins gathered in synchroniser order
   assign pins_raw = {brown_out_pin, por_released_pin, write_protect_pin,
                      chip_select_bit_2, chip_select_bit_1, chip_select_bit_0,
                      sda_pin_in, scl_pin};

   // Three stages; a level counts once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++)
      begin : g_sync
         always_ff @(posedge ref_clk)
         begin
            if (!rst_b)
            begin
               sync1_q[gi] <= SYNC_RST[gi];
               sync2_q[gi] <= SYNC_RST[gi];
               sync3_q[gi] <= SYNC_RST[gi];
               filt_q[gi]  <= SYNC_RST[gi];
            end
            else
            begin
               sync1_q[gi] <= pins_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
               sync3_q[gi] <= sync2_q[gi];
               if (sync2_q[gi] == sync3_q[gi])
                  filt_q[gi] <= sync3_q[gi];
            end
         end
      end
   endgenerate
   // ==========================================================
   // Bus condition detection
   // ==========================================================
   logic scl_prev_q, sda_prev_q, por_prev_q;
   logic scl_rise, scl_fall, start_det, stop_det;
   // Previous filtered levels for edge finding
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         scl_prev_q <= SYNC_RST[IX_SCL];
         sda_prev_q <= SYNC_RST[IX_SDA];
         por_prev_q <= SYNC_RST[IX_POR];
      end
      else
      begin
         scl_prev_q <= filt_q[IX_SCL];
         sda_prev_q <= filt_q[IX_SDA];
         por_prev_q <= filt_q[IX_POR];
      end
   end

   assign scl_rise  = filt_q[IX_SCL] & ~scl_prev_q;  // RULE21
   assign scl_fall  = ~filt_q[IX_SCL] & scl_prev_q;  // RULE21
   assign start_det = filt_q[IX_SCL] & scl_prev_q & sda_prev_q & ~filt_q[IX_SDA];  // RULE22
   assign stop_det  = filt_q[IX_SCL] & scl_prev_q & ~sda_prev_q & filt_q[IX_SDA];  // RULE1
   // ==========================================================
   // Power-on and brown-out gating
   // ==========================================================
   logic live_q, proto_rst;
   // Brown-out kills the logic until power-on releases again
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         live_q <= 1'b0;
      else if (filt_q[IX_BOR])
         live_q <= 1'b0;  // RULE8
      else if (filt_q[IX_POR] & ~por_prev_q)
         live_q <= 1'b1;  // RULE6
   end

   assign proto_rst = ~rst_b | ~live_q | filt_q[IX_BOR] | ~filt_q[IX_POR];  // RULE6 RULE8
   // ==========================================================
   // Protocol state and byte framing
   // ==========================================================
   eebsf_state_t state_q;
   logic [3:0]   bit_cnt_q;
   logic [7:0]   rx_q, tx_q, rx_byte;
   logic [2:0]   cs_pins, id_func_q;
   logic [15:0]  waddr_q;
   logic         ack_phase_q, ack_ok_q, wr_pending_q, sda_oe_q;
   logic         dev_match, data_ok, sel_id_q, op_read_q;
   // Byte as it stands after the eighth rising edge
   assign rx_byte = rx_q;
   assign cs_pins = {filt_q[IX_CS2], filt_q[IX_CS1], filt_q[IX_CS0]};
   // Address byte compare; busy programming also refuses the address
   assign dev_match = ((rx_byte[DEV_TYPE_HI:DEV_TYPE_LO] == TYPE_ARRAY) |        // RULE11
                       (rx_byte[DEV_TYPE_HI:DEV_TYPE_LO] == TYPE_ID_SPACE)) &    // RULE12
                      (rx_byte[DEV_CS_HI:DEV_CS_LO] == cs_pins) &                // RULE13
                      ~write_busy;
   // Data byte accepted only when modification is allowed
   assign data_ok = ~filt_q[IX_WP] &  // RULE9 RULE23
                    (~sel_id_q | (((id_func_q == FN_ID_PAGE) | (id_func_q == FN_LOCK)) &  // RULE18 RULE19
                                  ~id_page_locked));  // RULE20
   // Main sequencer: sampling on SCL rise, SDA changes on SCL fall
   always_ff @(posedge ref_clk)
   begin
      if (proto_rst)
      begin
         state_q      <= EEBSF_IDLE;  // RULE4 RULE6
         bit_cnt_q    <= BIT_CNT_RST;
         rx_q         <= BYTE_RST;
         tx_q         <= BYTE_RST;
         ack_phase_q  <= 1'b0;
         ack_ok_q     <= 1'b0;
         wr_pending_q <= 1'b0;
         sda_oe_q     <= 1'b0;
      end
      else if (start_det)
      begin
         state_q      <= EEBSF_DEV_ADDR;  // RULE22 RULE25
         bit_cnt_q    <= BIT_CNT_RST;
         ack_phase_q  <= 1'b0;
         wr_pending_q <= 1'b0;
         sda_oe_q     <= 1'b0;
      end
      else if (stop_det)
      begin
         state_q      <= EEBSF_IDLE;  // RULE1 RULE2
         bit_cnt_q    <= BIT_CNT_RST;
         ack_phase_q  <= 1'b0;
         wr_pending_q <= 1'b0;
         sda_oe_q     <= 1'b0;
      end
      else if (state_q == EEBSF_RD_DATA)
      begin
         if (scl_rise)
         begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            // Master leaves SDA high at the ninth clock: read ends
            if (bit_cnt_q == BITS_IN_BYTE && filt_q[IX_SDA])
               state_q <= EEBSF_WAIT;
         end
         else if (scl_fall)
         begin
            if (bit_cnt_q == BITS_IN_BYTE)
               sda_oe_q <= 1'b0;  // RULE24
            else if (bit_cnt_q == BITS_WITH_ACK)
            begin
               tx_q      <= rd_byte;
               sda_oe_q  <= ~rd_byte[7];  // RULE24
               bit_cnt_q <= BIT_CNT_RST;
            end
            else
            begin
               tx_q     <= {tx_q[6:0], 1'b0};
               sda_oe_q <= ~tx_q[6];  // RULE21
            end
         end
      end
      else if (state_q != EEBSF_IDLE && state_q != EEBSF_WAIT)
      begin
         if (scl_rise && !ack_phase_q)
         begin
            rx_q      <= {rx_q[6:0], filt_q[IX_SDA]};  // RULE10 RULE21
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
         else if (scl_fall && !ack_phase_q && bit_cnt_q == BITS_IN_BYTE)
         begin
            // Decide the answer for the ninth clock
            ack_phase_q <= 1'b1;
            unique case (state_q)
               EEBSF_DEV_ADDR:
               begin
                  ack_ok_q <= dev_match;  // RULE15
                  sda_oe_q <= dev_match;  // RULE3
               end
               EEBSF_WR_DATA:
               begin
                  ack_ok_q <= data_ok;  // RULE23
                  sda_oe_q <= data_ok;  // RULE3 RULE9
                  if (data_ok)
                     wr_pending_q <= 1'b1;
               end
               default:
               begin
                  ack_ok_q <= 1'b1;  // RULE16 RULE23
                  sda_oe_q <= 1'b1;  // RULE3
               end
            endcase
         end
         else if (scl_fall && ack_phase_q)
         begin
            // Ninth clock over: release and move on
            ack_phase_q <= 1'b0;
            bit_cnt_q   <= BIT_CNT_RST;
            sda_oe_q    <= 1'b0;  // RULE24
            unique case (state_q)
               EEBSF_DEV_ADDR:
               begin
                  if (!ack_ok_q)
                     state_q <= EEBSF_WAIT;  // RULE15
                  else if (op_read_q)
                  begin
                     state_q  <= EEBSF_RD_DATA;
                     tx_q     <= rd_byte;
                     sda_oe_q <= ~rd_byte[7];  // RULE21 RULE24
                  end
                  else
                     state_q <= EEBSF_ADDR_HI;  // RULE16
               end
               EEBSF_ADDR_HI: state_q <= EEBSF_ADDR_LO;  // RULE16
               EEBSF_ADDR_LO: state_q <= EEBSF_WR_DATA;
               default:       state_q <= state_q;
            endcase
         end
      end
   end
   // ==========================================================
   // Decoded operation and word address
   // ==========================================================
   logic byte_done;
   assign byte_done = scl_fall & ~ack_phase_q & (bit_cnt_q == BITS_IN_BYTE) & ~start_det & ~stop_det;
   // Capture device address fields and the two word address bytes
   always_ff @(posedge ref_clk)
   begin
      if (proto_rst)
      begin
         sel_id_q  <= 1'b0;
         op_read_q <= 1'b0;
         waddr_q   <= WADDR_RST;
         id_func_q <= FN_RST;
      end
      else if (byte_done)
      begin
         unique case (state_q)
            EEBSF_DEV_ADDR:
            begin
               if (dev_match)
               begin
                  sel_id_q  <= (rx_byte[DEV_TYPE_HI:DEV_TYPE_LO] == TYPE_ID_SPACE);  // RULE12
                  op_read_q <= rx_byte[DEV_RW_BIT];  // RULE14
               end
            end
            EEBSF_ADDR_HI:
            begin
               waddr_q[15:8] <= rx_byte;  // RULE16 RULE17
               id_func_q     <= rx_byte[FN_HI-8:FN_LO-8];  // RULE18
            end
            EEBSF_ADDR_LO: waddr_q[7:0] <= rx_byte;  // RULE16 RULE17
            default:       waddr_q <= waddr_q;
         endcase
      end
   end
   // ==========================================================
   // Event pulses to the array side
   // ==========================================================
   logic         bus_stop_q, prog_start_q, addr_valid_q, rd_taken_q, wr_valid_q, standby_q, rd_load;
   logic [7:0]   wr_byte_q;
   assign rd_load = scl_fall & ~start_det & ~stop_det &
                    (((state_q == EEBSF_RD_DATA) & (bit_cnt_q == BITS_WITH_ACK)) |
                     ((state_q == EEBSF_DEV_ADDR) & ack_phase_q & ack_ok_q & op_read_q));
   // One-cycle strobes; programming only after an accepted data byte
   always_ff @(posedge ref_clk)
   begin
      if (proto_rst)
      begin
         bus_stop_q   <= 1'b0;
         prog_start_q <= 1'b0;
         addr_valid_q <= 1'b0;
         rd_taken_q   <= 1'b0;
         wr_valid_q   <= 1'b0;
         wr_byte_q    <= BYTE_RST;
      end
      else
      begin
         bus_stop_q   <= stop_det;  // RULE1
         prog_start_q <= stop_det & (state_q == EEBSF_WR_DATA) & wr_pending_q &
                         ~ack_phase_q & (bit_cnt_q <= 4'h1);  // RULE2
         addr_valid_q <= byte_done & (state_q == EEBSF_ADDR_LO);  // RULE17 RULE18
         rd_taken_q   <= rd_load;
         wr_valid_q   <= byte_done & (state_q == EEBSF_WR_DATA) & data_ok;  // RULE9
         if (byte_done && state_q == EEBSF_WR_DATA)
            wr_byte_q <= rx_byte;
      end
   end
   // Standby while idle and no internal operation runs
   always_ff @(posedge ref_clk)
   begin
      if (proto_rst)
         standby_q <= 1'b1;  // RULE4
      else
         standby_q <= (state_q == EEBSF_IDLE || state_q == EEBSF_WAIT) & ~write_busy;  // RULE2 RULE4
   end
   // ==========================================================
   // Outputs, all from flip-flops except sda_pin_out, which is tied low
   // ==========================================================
   assign sda_pin_out       = 1'b0;  // RULE24
   assign sda_pin_oe        = sda_oe_q;
   assign standby           = standby_q;
   assign bus_stop          = bus_stop_q;
   assign prog_start        = prog_start_q;
   assign addr_valid        = addr_valid_q;
   assign word_address_bits = waddr_q;
   assign sel_id_space      = sel_id_q;
   assign id_func           = id_func_q;
   assign op_read           = op_read_q;
   assign rd_byte_taken     = rd_taken_q;
   assign wr_byte_valid     = wr_valid_q;
   assign wr_byte           = wr_byte_q;
endmodule

`default_nettype wire

// File: test/eebsf_front_end_asserts.sv
// Concurrent checks on the EEPROM bus slave front end ports
`timescale 1ns/100ps
`default_nettype none

module eebsf_front_end_asserts
   import eebsf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic scl_pin,
   input wire logic sda_pin_out,
   input wire logic sda_pin_oe,
   input wire logic write_protect_pin,
   input wire logic brown_out_pin,
   input wire logic write_busy,
   input wire logic standby,
   input wire logic bus_stop,
   input wire logic prog_start,
   input wire logic addr_valid,
   input wire logic op_read,
   input wire logic rd_byte_taken,
   input wire logic wr_byte_valid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // ==========================================================
   // Sequences
   // ==========================================================
   // Brown-out held long enough to cross the synchroniser
   sequence s_bor_held;
      brown_out_pin [*5];
   endsequence
   // Stop seen as a single cycle pulse
   sequence s_stop_pulse;
      bus_stop ##1 !bus_stop;
   endsequence

   // ==========================================================
   // Properties
   // ==========================================================
   a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !sda_pin_oe && standby && !prog_start)
      else $error("outputs active during reset");
   a_stop_single: assert property (bus_stop |-> s_stop_pulse)
      else $error("stop pulse longer than one cycle");
   a_prog_on_stop: assert property (prog_start |-> (bus_stop || $past(bus_stop)) && !op_read)
      else $error("programming started without a write stop");
   a_oe_scl_low: assert property ($changed(sda_pin_oe) |-> !scl_pin)
      else $error("data line changed while clock high");
   a_never_high: assert property (sda_pin_out == 1'b0)
      else $error("data line driven high");
   a_oe_not_idle: assert property (sda_pin_oe |-> !standby)
      else $error("data line pulled while in standby");
   a_taken_read: assert property (rd_byte_taken |-> op_read)
      else $error("read byte taken during a write");
   a_wp_no_data: assert property (wr_byte_valid |-> !write_protect_pin)
      else $error("data accepted while write protected");
   a_bor_silent: assert property (s_bor_held |-> !sda_pin_oe && standby)
      else $error("device active during brown-out");
   a_busy_awake: assert property (write_busy ##1 write_busy |-> !standby)
      else $error("standby shown while programming");
   a_addr_single: assert property (addr_valid |-> !op_read ##1 !addr_valid)
      else $error("address valid pulse malformed");
endmodule

`default_nettype wire

// File: test/eebsf_bus_master.sv
// Behavioural two-wire bus master facing the front end
`timescale 1ns/100ps
`default_nettype none

module eebsf_bus_master
(
   output logic     scl,
   output logic     sda_low,
   input wire logic sda
);
   // Clock stands high and data is released between frames
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // One bit: data set while low, sampled mid high
   task automatic clk_bit(input logic b, output logic r);
      sda_low = ~b;
      #125 scl = 1'b1;
      #100 r = sda;
      #100 scl = 1'b0;
      #125;
   endtask

   task automatic start_cond();
      sda_low = 1'b0;
      #125 scl = 1'b1;
      #200 sda_low = 1'b1;
      #200 scl = 1'b0;
      #125;
   endtask

   task automatic stop_cond();
      sda_low = 1'b1;
      #125 scl = 1'b1;
      #200 sda_low = 1'b0;
      #200;
   endtask

   // Byte out MSB first, then released ninth clock for the answer
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         clk_bit(d[i], r);
      clk_bit(1'b1, r);
      ack = ~r;
   endtask

   task automatic read_byte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         clk_bit(1'b1, d[i]);
      clk_bit(~mack, r);
   endtask
endmodule

`default_nettype wire

// File: test/tb_eebsf_front_end.sv
// Self-checking bench for the EEPROM bus slave front end
`timescale 1ns/100ps
`default_nettype none

module tb_eebsf_front_end;
   import eebsf_pkg::*;
   localparam logic [2:0] CSV  = 3'h5;
   localparam logic [7:0] WR_A = {TYPE_ARRAY, CSV, 1'b0};
   localparam logic [7:0] WR_I = {TYPE_ID_SPACE, CSV, 1'b0};
   logic        ref_clk, rst_b, scl, m_low, wp, por, bor, busy, locked, ack;
   logic        oe, standby, bus_stop, prog_start, sel_id, op_read;
   logic [7:0]  rd_byte, wr_byte, rx;
   logic [15:0] waddr;
   logic [2:0]  id_func, cs;
   int          fails, cmp_count, n_prog;
   wire         sda_line = ~(m_low | oe);

   eebsf_bus_master eebsf_bus_master_inst (.scl(scl), .sda_low(m_low), .sda(sda_line));
   eebsf_front_end eebsf_front_end_inst (.ref_clk(ref_clk), .rst_b(rst_b), .scl_pin(scl),
      .sda_pin_in(sda_line), .sda_pin_out(), .sda_pin_oe(oe), .chip_select_bit_0(cs[0]),
      .chip_select_bit_1(cs[1]), .chip_select_bit_2(cs[2]), .write_protect_pin(wp),
      .por_released_pin(por), .brown_out_pin(bor), .write_busy(busy), .id_page_locked(locked),
      .rd_byte(rd_byte), .standby(standby), .bus_stop(bus_stop), .prog_start(prog_start),
      .addr_valid(), .word_address_bits(waddr), .sel_id_space(sel_id), .id_func(id_func),
      .op_read(op_read), .rd_byte_taken(), .wr_byte_valid(), .wr_byte(wr_byte));

   // Clock and programming pulse counter
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (prog_start === 1'b1)
         n_prog++;

   task automatic complete_run();
      if (fails == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Start, one address byte, expected answer, Stop
   task automatic dev_only(input logic [7:0] d, input logic exp);
      eebsf_bus_master_inst.start_cond();
      eebsf_bus_master_inst.send_byte(d, ack);
      chk_bit(ack, exp);
      eebsf_bus_master_inst.stop_cond();
   endtask

   // Write header then one data byte; returns the data answer
   task automatic wr_seq(input logic [7:0] d, input logic [7:0] hi, input logic [7:0] dat);
      eebsf_bus_master_inst.start_cond();
      eebsf_bus_master_inst.send_byte(d, ack);
      chk_bit(ack, 1'b1);
      eebsf_bus_master_inst.send_byte(hi, ack);
      chk_bit(ack, 1'b1);
      eebsf_bus_master_inst.send_byte(8'h34, ack);
      chk_bit(ack, 1'b1);
      eebsf_bus_master_inst.send_byte(dat, ack);
   endtask

   task automatic t_power();
      dev_only(WR_A, 1'b0);
      por = 1'b1;
      tick(20);
      chk_bit(standby, 1'b1);
      dev_only(WR_A, 1'b1);
      bor = 1'b1;
      tick(10);
      bor = 1'b0;
      tick(10);
      dev_only(WR_A, 1'b0);
      por = 1'b0;
      tick(10);
      por = 1'b1;
      tick(20);
      dev_only(WR_A, 1'b1);
   endtask

   task automatic t_write();
      int p;
      p = n_prog;
      wr_seq(WR_A, 8'h9b, 8'ha5);
      chk_bit(ack, 1'b1);
      chk_val(waddr, 16'h9b34);
      chk_val(16'({sel_id, op_read}), 16'h0);
      chk_val(16'(wr_byte), 16'h00a5);
      eebsf_bus_master_inst.stop_cond();
      chk_val(16'(n_prog - p), 16'h1);
   endtask

   task automatic t_protect();
      int p;
      p = n_prog;
      tick(1);
      wp = 1'b1;
      wr_seq(WR_A, 8'h01, 8'h5a);
      chk_bit(ack, 1'b0);
      eebsf_bus_master_inst.stop_cond();
      chk_val(16'(n_prog - p), 16'h0);
      wp = 1'b0;
   endtask

   // Identification space: function field with don't-care bits set
   task automatic t_id(input logic [2:0] fn, input logic lk, input logic exp);
      tick(1);
      locked = lk;
      wr_seq(WR_I, {4'hf, fn, 1'b1}, 8'h02);
      chk_bit(ack, exp);
      chk_val({12'h0, sel_id, id_func}, {12'h0, 1'b1, fn});
      eebsf_bus_master_inst.stop_cond();
      locked = 1'b0;
   endtask

   task automatic t_read(input logic [3:0] typ);
      eebsf_bus_master_inst.start_cond();
      eebsf_bus_master_inst.send_byte({typ, CSV, 1'b1}, ack);
      chk_bit(ack, 1'b1);
      eebsf_bus_master_inst.read_byte(1'b0, rx);
      chk_val(16'(rx), 16'h00c3);
      chk_bit(op_read, 1'b1);
      eebsf_bus_master_inst.stop_cond();
      tick(4);
      chk_bit(standby, 1'b1);
   endtask

   task automatic t_misc();
      logic r;
      for (int i = 0; i < 3; i++)
         dev_only({TYPE_ARRAY, CSV ^ 3'(1 << i), 1'b0}, 1'b0);
      dev_only(8'h30, 1'b0);
      cs = 3'h2;
      dev_only(WR_A, 1'b0);
      dev_only({TYPE_ARRAY, 3'h2, 1'b0}, 1'b1);
      cs = CSV;
      busy = 1'b1;
      tick(4);
      chk_bit(standby, 1'b0);
      dev_only(WR_A, 1'b0);
      busy = 1'b0;
      eebsf_bus_master_inst.start_cond();
      for (int i = 0; i < 4; i++)
         eebsf_bus_master_inst.clk_bit(1'b0, r);
      dev_only(WR_A, 1'b1);
      eebsf_bus_master_inst.start_cond();
      for (int i = 0; i < 9; i++)
         eebsf_bus_master_inst.clk_bit(1'b1, r);
      dev_only(WR_A, 1'b1);
   endtask

   // Main sequence with a watchdog beside it
   initial
   begin
      ref_clk = 1'b0;
      rst_b = 1'b0;
      {cs, wp, por, bor, busy, locked} = {CSV, 5'h00};
      rd_byte = 8'hc3;
      tick(2);
      rst_b = 1'b1;
      t_power();
      t_write();
      t_protect();
      t_id(FN_ID_PAGE, 1'b0, 1'b1);
      t_id(FN_LOCK, 1'b0, 1'b1);
      t_id(FN_UNIQUE_ID, 1'b0, 1'b0);
      t_id(FN_ID_PAGE, 1'b1, 1'b0);
      t_read(TYPE_ARRAY);
      t_read(TYPE_ID_SPACE);
      t_misc();
      complete_run();
   end
   initial
   begin
      #2ms fails++;
      complete_run();
   end
endmodule

bind eebsf_front_end eebsf_front_end_asserts eebsf_front_end_asserts_inst (.ref_clk(ref_clk), .rst_b(rst_b),
   .scl_pin(scl_pin), .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe), .write_protect_pin(write_protect_pin),
   .brown_out_pin(brown_out_pin), .write_busy(write_busy), .standby(standby), .bus_stop(bus_stop),
   .prog_start(prog_start), .addr_valid(addr_valid), .op_read(op_read), .rd_byte_taken(rd_byte_taken),
   .wr_byte_valid(wr_byte_valid));

`default_nettype wire
